// ### design/transfer_controller.v
// Interrupt-triggered data transfer controller with chain and sequence transfer
`timescale 1ns/1ps
`default_nettype none
`include "transfer_controller_defs.vh"

// What this block does
// - Normal mode moves one unit per activation
// - Repeat mode reloads start address at size
// - Repeat size up to 256 units
// - Block mode moves whole block per activation
// - Block length 1 to 256 units
// - Unit is byte, word or longword
// - Chain runs following information sets in turn
// - Chain every time or at count zero
// - One channel per activating interrupt source
// - Sequence accepts one selected trigger source
// - Up to 256 sequences per trigger
// - First transferred data indexes the table
// - Sequence ends, or suspends and resumes later
// - Short mode limits addresses to two areas
// - Full mode spans whole 32-bit space
// - CPU interrupt after each transfer if chosen
// - CPU interrupt when counter is exhausted, in normal and block mode
// - Event link after each transfer or block
// - Read skip reuses held info on same channel
// - Unchanged address fields are not written back
// - Write-back disable suppresses all write-back
// - Optional displacement added to source address
module transfer_controller (
	input wire sys_clk,
	input wire reset,
	input wire clkEn,
	input wire [`TC_NSRC-1:0] actReq,
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdata,
	output reg memReq,
	output reg memWe,
	output reg [31:0] memAddr,
	output reg [31:0] memWdata,
	output reg [1:0] memSize,
	input wire [31:0] memRdata,
	input wire memAck,
	output reg cpuIrq,
	output reg eventLink
);
	localparam S_IDLE = 3'h0;
	localparam S_FETCH = 3'h1;
	localparam S_READ = 3'h2;
	localparam S_WRITE = 3'h3;
	localparam S_WBACK = 3'h4;
	localparam S_NEXT = 3'h5;
	localparam S_INDEX = 3'h6;

	reg [2:0] state_r;
	reg [`TC_NSRC-1:0] pend_r;
	reg [2:0] opCtl_r;
	reg [31:0] vecBase_r;
	reg [31:0] idxBase_r;
	reg [3:0] seqEn_r;
	reg [31:0] disp_r;
	reg [31:0] mode_r;
	reg [31:0] src_r;
	reg [31:0] dst_r;
	reg [31:0] cnt_r;
	reg [31:0] data_r;
	reg [31:0] infoPtr_r;
	reg [31:0] resumePtr_r;
	reg [1:0] word_r;
	reg [`TC_CHW-1:0] chan_r;
	reg [`TC_CHW-1:0] lastCh_r;
	reg cacheOk_r;
	reg chained_r;
	reg inSeq_r;
	reg firstSeq_r;
	reg seqSusp_r;
	reg [`TC_NSRC-1:0] pend_nxt;

	wire [1:0] unitSize = mode_r[`TC_MODE_SIZE_HI:`TC_MODE_SIZE_LO];
	wire [1:0] xferMode = mode_r[`TC_MODE_XFER_HI:`TC_MODE_XFER_LO];
	wire shortMode = opCtl_r[`TC_OPCTL_SHORT];
	wire [`TC_CHW-1:0] seqSrc = seqEn_r[`TC_SEQEN_SRC_HI:`TC_SEQEN_SRC_LO];
	wire [31:0] srcEff;
	wire [31:0] srcNext;
	wire [31:0] dstEff;
	wire [31:0] dstNext;

	tc_address_unit srcUnit (
		.addr(src_r),
		.unitSize(unitSize),
		.stepEn(mode_r[`TC_MODE_SRC_INC]),
		.dispEn(mode_r[`TC_MODE_DISP]),
		.disp(disp_r),
		.shortMode(shortMode),
		.effAddr(srcEff),
		.nextAddr(srcNext)
	);

	tc_address_unit dstUnit (
		.addr(dst_r),
		.unitSize(unitSize),
		.stepEn(mode_r[`TC_MODE_DST_INC]),
		.dispEn(1'b0),
		.disp(disp_r),
		.shortMode(shortMode),
		.effAddr(dstEff),
		.nextAddr(dstNext)
	);

	// Lowest source number wins when several are pending
	reg anyPend;
	reg [`TC_CHW-1:0] pickCh;
	integer i;
	always @* begin
		anyPend = 1'b0;
		pickCh = {`TC_CHW{1'b0}};
		for (i = `TC_NSRC - 1; i >= 0; i = i - 1) begin
			if (pend_r[i]) begin
				anyPend = 1'b1;
				pickCh = i[`TC_CHW-1:0];
			end
		end
	end

	// Size field 0 means 256 units, so the unit count is nine bits wide
	wire [8:0] sizeUnits = (cnt_r[7:0] == 8'h00) ? 9'h100 : {1'b0, cnt_r[7:0]};
	wire [31:0] span = {21'h000000, sizeUnits, 2'h0} >> (3'h2 - {1'b0, unitSize});
	wire remLast = (cnt_r[15:8] == 8'h01);
	wire cntLast = (cnt_r[31:16] == 16'h0001);
	wire rptDst = mode_r[`TC_MODE_RPT_DST];
	wire pickSeq = seqEn_r[`TC_SEQEN_ON] && (pickCh == seqSrc);

	// Write-back step plan: skip fixed address fields
	wire wbNeeded = (word_r == 2'h1) ? mode_r[`TC_MODE_SRC_INC] :
		(word_r == 2'h2) ? mode_r[`TC_MODE_DST_INC] : 1'b1;

	// Pending latch: a new request beats the clear of the same bit
	always @* begin
		pend_nxt = pend_r;
		if (state_r == S_IDLE && opCtl_r[`TC_OPCTL_ENABLE] && anyPend) begin
			pend_nxt[pickCh] = 1'b0;
		end
		pend_nxt = pend_nxt | actReq;
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			state_r <= S_IDLE;
			pend_r <= {`TC_NSRC{1'b0}};
			opCtl_r <= 3'h0;
			vecBase_r <= 32'h00000000;
			idxBase_r <= 32'h00000000;
			seqEn_r <= 4'h0;
			disp_r <= 32'h00000000;
			mode_r <= 32'h00000000;
			src_r <= 32'h00000000;
			dst_r <= 32'h00000000;
			cnt_r <= 32'h00000000;
			data_r <= 32'h00000000;
			infoPtr_r <= 32'h00000000;
			resumePtr_r <= 32'h00000000;
			word_r <= 2'h0;
			chan_r <= {`TC_CHW{1'b0}};
			lastCh_r <= {`TC_CHW{1'b0}};
			cacheOk_r <= 1'b0;
			chained_r <= 1'b0;
			inSeq_r <= 1'b0;
			firstSeq_r <= 1'b0;
			seqSusp_r <= 1'b0;
			regRdata <= 32'h00000000;
			memReq <= 1'b0;
			memWe <= 1'b0;
			memAddr <= 32'h00000000;
			memWdata <= 32'h00000000;
			memSize <= 2'h0;
			cpuIrq <= 1'b0;
			eventLink <= 1'b0;
		end else if (clkEn) begin
			pend_r <= pend_nxt;
			cpuIrq <= 1'b0;
			eventLink <= 1'b0;
			if (regWr) begin
				case (regAddr)
					`TC_REG_OPCTL: opCtl_r <= regWdata[2:0];
					`TC_REG_VECBASE: vecBase_r <= regWdata;
					`TC_REG_IDXBASE: idxBase_r <= regWdata;
					`TC_REG_SEQEN: begin
						seqEn_r <= regWdata[3:0];
						seqSusp_r <= 1'b0;
					end
					`TC_REG_DISP: disp_r <= regWdata;
					default: ;
				endcase
				// Software may have rewritten info in memory
				cacheOk_r <= 1'b0;
			end
			regRdata <= 32'h00000000;
			if (regRd) begin
				case (regAddr)
					`TC_REG_OPCTL: regRdata <= {29'h00000000, opCtl_r};
					`TC_REG_VECBASE: regRdata <= vecBase_r;
					`TC_REG_IDXBASE: regRdata <= idxBase_r;
					`TC_REG_SEQEN: regRdata <= {28'h0000000, seqEn_r};
					`TC_REG_DISP: regRdata <= disp_r;
					`TC_REG_STATUS: regRdata <= {24'h000000, seqSusp_r, inSeq_r, (state_r != S_IDLE), 2'h0, chan_r};
					default: regRdata <= 32'h00000000;
				endcase
			end
			case (state_r)
				S_IDLE: begin
					if (opCtl_r[`TC_OPCTL_ENABLE] && anyPend) begin
						chan_r <= pickCh;
						chained_r <= 1'b0;
						inSeq_r <= pickSeq;
						firstSeq_r <= pickSeq && !seqSusp_r;
						word_r <= 2'h0;
						if (pickSeq && seqSusp_r) begin
							infoPtr_r <= resumePtr_r;
							seqSusp_r <= 1'b0;
							state_r <= S_FETCH;
						end else begin
							infoPtr_r <= vecBase_r + {25'h0000000, pickCh, 4'h0};
							if (!pickSeq && opCtl_r[`TC_OPCTL_RDSKIP] && cacheOk_r && lastCh_r == pickCh) begin
								state_r <= S_READ;
							end else begin
								state_r <= S_FETCH;
							end
						end
					end
				end
				S_FETCH: begin
					memReq <= 1'b1;
					memWe <= 1'b0;
					memSize <= `TC_SIZE_LONG;
					memAddr <= infoPtr_r + {28'h0000000, word_r, 2'h0};
					if (memReq && memAck) begin
						memReq <= 1'b0;
						case (word_r)
							2'h0: mode_r <= memRdata;
							2'h1: src_r <= memRdata;
							2'h2: dst_r <= memRdata;
							default: cnt_r <= memRdata;
						endcase
						word_r <= word_r + 2'h1;
						if (word_r == `TC_INFO_WORDS) begin
							state_r <= S_READ;
						end
					end
				end
				S_READ: begin
					memReq <= 1'b1;
					memWe <= 1'b0;
					memSize <= unitSize;
					memAddr <= srcEff;
					if (memReq && memAck) begin
						memReq <= 1'b0;
						data_r <= memRdata;
						state_r <= S_WRITE;
					end
				end
				S_WRITE: begin
					memReq <= 1'b1;
					memWe <= 1'b1;
					memSize <= unitSize;
					memAddr <= dstEff;
					memWdata <= data_r;
					if (memReq && memAck) begin
						memReq <= 1'b0;
						memWe <= 1'b0;
						src_r <= srcNext;
						dst_r <= dstNext;
						word_r <= 2'h1;
						case (xferMode)
							`TC_XFER_REPEAT: begin
								cnt_r[15:8] <= remLast ? cnt_r[7:0] : cnt_r[15:8] - 8'h01;
								if (remLast) begin
									if (rptDst) begin
										dst_r <= mode_r[`TC_MODE_DST_INC] ? dstNext - span : dst_r;
									end else begin
										src_r <= mode_r[`TC_MODE_SRC_INC] ? srcNext - span : src_r;
									end
								end
								eventLink <= 1'b1;
								cpuIrq <= mode_r[`TC_MODE_IRQ_EACH];
								state_r <= mode_r[`TC_MODE_WRITEBACK_DISABLE] ? S_NEXT : S_WBACK;
							end
							`TC_XFER_BLOCK: begin
								if (!remLast) begin
									cnt_r[15:8] <= cnt_r[15:8] - 8'h01;
									state_r <= S_READ;
								end else begin
									cnt_r[15:8] <= cnt_r[7:0];
									cnt_r[31:16] <= cnt_r[31:16] - 16'h0001;
									if (rptDst) begin
										dst_r <= mode_r[`TC_MODE_DST_INC] ? dstNext - span : dst_r;
									end else begin
										src_r <= mode_r[`TC_MODE_SRC_INC] ? srcNext - span : src_r;
									end
									eventLink <= 1'b1;
									cpuIrq <= mode_r[`TC_MODE_IRQ_EACH] || cntLast;
									state_r <= mode_r[`TC_MODE_WRITEBACK_DISABLE] ? S_NEXT : S_WBACK;
								end
							end
							default: begin
								cnt_r[31:16] <= cnt_r[31:16] - 16'h0001;
								eventLink <= 1'b1;
								cpuIrq <= mode_r[`TC_MODE_IRQ_EACH] || cntLast;
								state_r <= mode_r[`TC_MODE_WRITEBACK_DISABLE] ? S_NEXT : S_WBACK;
							end
						endcase
					end
				end
				S_WBACK: begin
					if (!wbNeeded && !memReq) begin
						word_r <= word_r + 2'h1;
					end else begin
						memReq <= 1'b1;
						memWe <= 1'b1;
						memSize <= `TC_SIZE_LONG;
						memAddr <= infoPtr_r + {28'h0000000, word_r, 2'h0};
						memWdata <= (word_r == 2'h1) ? src_r : (word_r == 2'h2) ? dst_r : cnt_r;
						if (memReq && memAck) begin
							memReq <= 1'b0;
							memWe <= 1'b0;
							word_r <= word_r + 2'h1;
							if (word_r == `TC_INFO_WORDS) begin
								state_r <= S_NEXT;
							end
						end
					end
				end
				S_NEXT: begin
					word_r <= 2'h0;
					if (firstSeq_r && mode_r[`TC_MODE_INDEX]) begin
						firstSeq_r <= 1'b0;
						state_r <= S_INDEX;
					end else if (mode_r[`TC_MODE_CHAIN] &&
						(!mode_r[`TC_MODE_CHAIN_ZERO] || cnt_r[31:16] == 16'h0000)) begin
						chained_r <= 1'b1;
						infoPtr_r <= infoPtr_r + `TC_INFO_STRIDE;
						state_r <= S_FETCH;
					end else begin
						if (inSeq_r && !mode_r[`TC_MODE_SEQEND]) begin
							seqSusp_r <= 1'b1;
							resumePtr_r <= infoPtr_r + `TC_INFO_STRIDE;
						end
						// Cache only a lone set, a chain would leave the last set held
						cacheOk_r <= !chained_r && !inSeq_r;
						lastCh_r <= chan_r;
						inSeq_r <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				S_INDEX: begin
					memReq <= 1'b1;
					memWe <= 1'b0;
					memSize <= `TC_SIZE_LONG;
					memAddr <= idxBase_r + {22'h000000, data_r[7:0], 2'h0};
					if (memReq && memAck) begin
						memReq <= 1'b0;
						chained_r <= 1'b1;
						infoPtr_r <= memRdata;
						state_r <= S_FETCH;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // transfer_controller

`default_nettype wire

// ### common/transfer_controller_defs.vh
// Constants for the interrupt-triggered transfer controller
`ifndef TRANSFER_CONTROLLER_DEFS_VH
`define TRANSFER_CONTROLLER_DEFS_VH

`define TC_NSRC 8
`define TC_CHW 3

`define TC_REG_OPCTL 8'h00
`define TC_REG_VECBASE 8'h04
`define TC_REG_IDXBASE 8'h08
`define TC_REG_SEQEN 8'h0C
`define TC_REG_DISP 8'h10
`define TC_REG_STATUS 8'h14

`define TC_OPCTL_ENABLE 0
`define TC_OPCTL_RDSKIP 1
`define TC_OPCTL_SHORT 2
`define TC_SEQEN_ON 0
`define TC_SEQEN_SRC_LO 1
`define TC_SEQEN_SRC_HI 3

`define TC_MODE_SIZE_LO 0
`define TC_MODE_SIZE_HI 1
`define TC_MODE_XFER_LO 2
`define TC_MODE_XFER_HI 3
`define TC_MODE_RPT_DST 4
`define TC_MODE_SRC_INC 5
`define TC_MODE_DST_INC 6
`define TC_MODE_CHAIN 7
`define TC_MODE_CHAIN_ZERO 8
`define TC_MODE_IRQ_EACH 9
`define TC_MODE_WRITEBACK_DISABLE 10
`define TC_MODE_SEQEND 11
`define TC_MODE_INDEX 12
`define TC_MODE_DISP 13

`define TC_XFER_NORMAL 2'h0
`define TC_XFER_REPEAT 2'h1
`define TC_XFER_BLOCK 2'h2

`define TC_SIZE_BYTE 2'h0
`define TC_SIZE_WORD 2'h1
`define TC_SIZE_LONG 2'h2

`define TC_INFO_STRIDE 32'h00000010
`define TC_INFO_WORDS 2'h3

`endif

// ### design/tc_address_unit.v
// Effective and next transfer address for one side
`timescale 1ns/1ps
`default_nettype none
`include "transfer_controller_defs.vh"

module tc_address_unit (
	input wire [31:0] addr,
	input wire [1:0] unitSize,
	input wire stepEn,
	input wire dispEn,
	input wire [31:0] disp,
	input wire shortMode,
	output reg [31:0] effAddr,
	output reg [31:0] nextAddr
);
	reg [31:0] raw;
	reg [31:0] step;

	always @* begin
		raw = dispEn ? addr + disp : addr;
		// Short mode reaches only the low and high 8 MB, so bit 23 fills the top byte
		effAddr = shortMode ? {{8{raw[23]}}, raw[23:0]} : raw;
		case (unitSize)
			`TC_SIZE_BYTE: step = 32'h00000001;
			`TC_SIZE_WORD: step = 32'h00000002;
			default: step = 32'h00000004;
		endcase
		nextAddr = stepEn ? addr + step : addr;
		if (shortMode) begin
			nextAddr = {{8{nextAddr[23]}}, nextAddr[23:0]};
		end
	end
endmodule // tc_address_unit

`default_nettype wire

// ### testbench/tc_checker.sv
// Port-level assertions for the transfer controller
`timescale 1ns/1ps
`default_nettype none
module tc_checker (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	input wire logic [1:0] memSize,
	input wire logic memAck,
	input wire logic cpuIrq,
	input wire logic eventLink
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
		else $error("request dropped or moved before ack");
	req_qual_a: assert property (memReq && !memAck |=> $stable(memWe) && $stable(memWdata) && $stable(memSize))
		else $error("request qualifiers changed before ack");
	req_drop_a: assert property (memReq && memAck |=> !memReq)
		else $error("request still high after ack");
	irq_pulse_a: assert property (cpuIrq |=> !cpuIrq)
		else $error("cpu interrupt longer than one cycle");
	irq_cause_a: assert property (cpuIrq |-> $past(memReq && memAck && memWe))
		else $error("cpu interrupt without a finished write");
	link_pulse_a: assert property (eventLink |=> !eventLink)
		else $error("event link longer than one cycle");
	link_cause_a: assert property (eventLink |-> $past(memReq && memAck && memWe))
		else $error("event link without a finished write");
	read_idle_a: assert property (!regRd |=> regRdata == 32'h00000000)
		else $error("read data outside its cycle");
	cover property (eventLink);
	cover property (cpuIrq);
	cover property (memReq && memAck && memWe);
endmodule // tc_checker

bind transfer_controller tc_checker chk_u (.sys_clk(sys_clk), .reset(reset), .regRd(regRd), .regRdata(regRdata),
	.memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize),
	.memAck(memAck), .cpuIrq(cpuIrq), .eventLink(eventLink));
`default_nettype wire

// ### testbench/tc_mem_model.sv
// Memory and bus responder on the controller's master port
`timescale 1ns/1ps
`default_nettype none
module tc_mem_model (
	input wire logic sys_clk,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	input wire logic [3:0] waitCycles,
	output var logic [31:0] memRdata,
	output var logic memAck
);
	logic [31:0] mem [0:255];
	logic [3:0] waitCnt;
	initial begin
		memAck = 1'b0;
		memRdata = 32'h00000000;
		waitCnt = 4'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 32'h00000000;
	end
	always @(posedge sys_clk) begin
		// Stale read data toggles so a late sample never looks valid
		memRdata <= ~memRdata;
		if (memAck || !memReq) begin
			memAck <= 1'b0;
			waitCnt <= 4'h0;
		end else if (waitCnt == waitCycles) begin
			memAck <= 1'b1;
			if (memWe)
				mem[memAddr[9:2]] <= memWdata;
			else
				memRdata <= mem[memAddr[9:2]];
		end else
			waitCnt <= waitCnt + 4'h1;
	end
endmodule // tc_mem_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the transfer controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk, reset, clkEn, regWr, regRd, memReq, memWe, memAck, cpuIrq, eventLink;
	logic [7:0] actReq, regAddr;
	logic [31:0] regWdata, regRdata, memAddr, memWdata, memRdata, rdAddr;
	logic [1:0] memSize, wrSize;
	logic [3:0] waitCycles;
	int err_count = 0, checked = 0, rdN = 0, wrN = 0, irqN = 0, evN = 0, cycles = 0;
	transfer_controller dut_u (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .actReq(actReq),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize),
		.memRdata(memRdata), .memAck(memAck), .cpuIrq(cpuIrq), .eventLink(eventLink));
	tc_mem_model mem_u (.sys_clk(sys_clk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
		.memWdata(memWdata), .waitCycles(waitCycles), .memRdata(memRdata), .memAck(memAck));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (memReq && memAck) begin
			if (memWe)
				wrN <= wrN + 1;
			else
				rdN <= rdN + 1;
			if (memWe && memAddr[9:8] == 2'h3)
				wrSize <= memSize;
			if (!memWe && memAddr[9:8] == 2'h2)
				rdAddr <= memAddr;
		end
		if (cpuIrq)
			irqN <= irqN + 1;
		if (eventLink)
			evN <= evN + 1;
		if (cycles == 20000) begin
			err_count++;
			$display("MISMATCH timeout expected idle seen busy");
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(name, regRdata, exp);
	endtask
	// Info sets sit at 0x100 + 16 * channel, data at 0x200 and 0x300
	task automatic setInfo(input int ch, input logic [31:0] m, s, d, c);
		mem_u.mem[64 + 4 * ch] = m;
		mem_u.mem[65 + 4 * ch] = s;
		mem_u.mem[66 + 4 * ch] = d;
		mem_u.mem[67 + 4 * ch] = c;
	endtask
	function automatic logic [31:0] info(input int ch, input int k);
		return mem_u.mem[64 + 4 * ch + k];
	endfunction
	function automatic logic [31:0] src(input int i);
		return 32'hC0DE0000 + i;
	endfunction
	function automatic logic [31:0] dst(input int i);
		return mem_u.mem[192 + i];
	endfunction
	task automatic fire(input int ch, er, ew, ei, ee, input bit frz, input string name);
		int r0, w0, i0, e0, quiet;
		r0 = rdN;
		w0 = wrN;
		i0 = irqN;
		e0 = evN;
		@(posedge sys_clk);
		actReq <= 8'h01 << ch;
		@(posedge sys_clk);
		actReq <= 8'h00;
		if (frz) begin
			// Frozen clock enable must hold the pending transfer back
			clkEn <= 1'b0;
			repeat (6) @(posedge sys_clk);
			chk("frozen request", {31'h0, memReq}, 32'h00000000);
			clkEn <= 1'b1;
		end
		quiet = 0;
		for (int k = 0; k < 3000 && quiet < 12; k++) begin
			@(posedge sys_clk);
			quiet = memReq ? 0 : quiet + 1;
		end
		chk({name, " reads"}, rdN - r0, er);
		chk({name, " writes"}, wrN - w0, ew);
		if (ei >= 0)
			chk({name, " irqs"}, irqN - i0, ei);
		chk({name, " events"}, evN - e0, ee);
		$display("done %s", name);
	endtask
	initial begin
		reset = 1'b1;
		clkEn = 1'b1;
		actReq = 8'h00;
		regAddr = 8'h00;
		regWdata = 32'h00000000;
		regWr = 1'b0;
		regRd = 1'b0;
		waitCycles = 4'h0;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 64; i++)
			mem_u.mem[128 + i] = src(i);
		wreg(8'h04, 32'h00000100);
		rreg(8'h04, 32'h00000100, "vector base");
		rreg(8'h30, 32'h00000000, "unmapped read");
		wreg(8'h00, 32'h00000001);
		setInfo(2, 32'h00000062, 32'h00000200, 32'h00000300, 32'h00010000);
		fire(2, 5, 4, 1, 1, 1'b1, "normal");
		chk("normal data", dst(0), src(0));
		chk("src back", info(2, 1), 32'h00000204);
		chk("count back", info(2, 3), 32'h00000000);
		wreg(8'h00, 32'h00000003);
		setInfo(1, 32'h00000262, 32'h00000210, 32'h00000310, 32'h00050000);
		fire(1, 5, 4, 1, 1, 1'b0, "irq each");
		fire(1, 1, 4, 1, 1, 1'b0, "read skip");
		chk("skip data", dst(5), src(5));
		wreg(8'h00, 32'h00000001);
		for (int s = 0; s < 3; s++) begin
			setInfo(3, s, 32'h00000220, 32'h00000320, 32'h00050000);
			fire(3, 5, 2, 0, 1, 1'b0, "unit size");
			chk("unit size", {30'h0, wrSize}, s);
		end
		setInfo(3, 32'h00000462, 32'h00000230, 32'h00000330, 32'h00050000);
		fire(3, 5, 1, 0, 1, 1'b0, "no write-back");
		chk("src kept", info(3, 1), 32'h00000230);
		wreg(8'h10, 32'h00000008);
		setInfo(4, 32'h00002002, 32'h00000240, 32'h00000340, 32'h00050000);
		fire(4, 5, 2, 0, 1, 1'b0, "displacement");
		chk("displaced data", dst(16), src(18));
		chk("displaced addr", rdAddr, 32'h00000248);
		waitCycles <= 4'h3;
		setInfo(5, 32'h0000006A, 32'h00000250, 32'h00000350, 32'h00010404);
		fire(5, 8, 7, 1, 1, 1'b0, "block of four");
		for (int i = 20; i < 24; i++)
			chk("block data", dst(i), src(i));
		waitCycles <= 4'h0;
		setInfo(5, 32'h0000000A, 32'h00000260, 32'h00000360, 32'h00010000);
		fire(5, 260, 257, 1, 1, 1'b0, "block of 256");
		setInfo(4, 32'h00000066, 32'h00000270, 32'h00000370, 32'h000A0202);
		for (int n = 0; n < 3; n++) begin
			fire(4, 5, 4, 0, 1, 1'b0, "repeat");
			if (n == 1)
				chk("repeat reload", info(4, 1), 32'h00000270);
		end
		chk("repeat wrap", dst(30), src(28));
		setInfo(5, 32'h00000182, 32'h00000280, 32'h00000380, 32'h00020000);
		setInfo(6, 32'h00000002, 32'h00000284, 32'h00000384, 32'h00050000);
		fire(5, 5, 2, 0, 1, 1'b0, "chain held");
		chk("chain not run", dst(33), 32'h00000000);
		fire(5, 10, 4, 1, 2, 1'b0, "chain at zero");
		chk("chain data", dst(33), src(33));
		// Trigger on source 7, index table entry for data 0x30 sits at 0x1C0
		wreg(8'h08, 32'h00000100);
		wreg(8'h0C, 32'h0000000F);
		mem_u.mem[112] = 32'h00000180;
		setInfo(7, 32'h00001002, 32'h000002C0, 32'h000003C0, 32'h00050000);
		setInfo(8, 32'h00000002, 32'h000002C4, 32'h000003C4, 32'h00050000);
		setInfo(9, 32'h00000802, 32'h000002C8, 32'h000003C8, 32'h00050000);
		fire(7, 11, 4, 0, 2, 1'b0, "sequence start");
		chk("trigger data", dst(48), src(48));
		chk("index data", dst(49), src(49));
		rreg(8'h14, 32'h00000087, "suspended");
		fire(7, 5, 2, 0, 1, 1'b0, "sequence resume");
		chk("resume data", dst(50), src(50));
		rreg(8'h14, 32'h00000007, "sequence done");
		wreg(8'h00, 32'h00000005);
		setInfo(0, 32'h00000002, 32'h00800234, 32'h000003D0, 32'h00050000);
		fire(0, 5, 2, 0, 1, 1'b0, "short address");
		chk("short address", rdAddr, 32'hFF800234);
		chk("short data", dst(52), src(13));
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
